/* design/baud_gen.sv */
// Baud-rate interval counter: reload, count down, one-cycle timeout pulse
`include "i2c_start_params.svh"
module baud_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control
   input wire logic load,
   input wire logic stop,
   input wire logic [`BAUD_W-1:0] reload,
   // Status
   output logic timeout
);
   logic [`BAUD_W-1:0] cnt_q;
   logic run_q;

   // Interval is reload+1 cycles; a stop wins over a running count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         timeout <= 1'b0;
      end else if (ce) begin
         timeout <= 1'b0;
         if (load) begin
            cnt_q <= reload;
            run_q <= 1'b1;
         end else if (stop) begin
            run_q <= 1'b0;
         end else if (run_q) begin
            if (cnt_q == '0) begin
               timeout <= 1'b1;
               run_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule

/* design/i2c_start_gen.sv */
// Start-condition generator of an I2C master port with an AXI4-Lite register slave
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "i2c_start_params.svh"
module i2c_start_gen
   import i2c_start_pkg::*;
(
   // Clock, reset, enable
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_CE,
   // AXI4-Lite write address and data
   input wire logic I_S_AXI_AWVALID,
   output logic O_S_AXI_AWREADY,
   input wire logic [`ADDR_W-1:0] I_S_AXI_AWADDR,
   input wire logic I_S_AXI_WVALID,
   output logic O_S_AXI_WREADY,
   input wire logic [31:0] I_S_AXI_WDATA,
   input wire logic [3:0] I_S_AXI_WSTRB,
   // AXI4-Lite write response
   output logic O_S_AXI_BVALID,
   input wire logic I_S_AXI_BREADY,
   output logic [1:0] O_S_AXI_BRESP,
   // AXI4-Lite read
   input wire logic I_S_AXI_ARVALID,
   output logic O_S_AXI_ARREADY,
   input wire logic [`ADDR_W-1:0] I_S_AXI_ARADDR,
   output logic O_S_AXI_RVALID,
   input wire logic I_S_AXI_RREADY,
   output logic [31:0] O_S_AXI_RDATA,
   output logic [1:0] O_S_AXI_RRESP,
   // I2C lines, open drain
   input wire logic I_SDA,
   output logic O_SDA,
   output logic O_SDA_OE,
   input wire logic I_SCL,
   output logic O_SCL,
   output logic O_SCL_OE,
   // Interrupt
   output logic O_IRQ
);
   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   start_state_t state_q;
   logic sda_s, scl_s;
   logic brg_load, brg_stop, brg_timeout;
   logic [`REG_W-1:0] ctrl2_q, xfer_q, w_data_q;
   logic [`BAUD_W-1:0] baud_q;
   logic [`IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
   logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic w_en_q, start_seen_q, rd_hit;
   logic [`ADDR_W-1:0] aw_addr_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_word;
   logic aw_take, w_take, aw_hold_d, w_hold_d, wr_fire, rd_take;
   logic wr_ctrl2, wr_baud, wr_xfer, wr_istat, wr_imask, wr_hit;
   logic busy, coll, done, sda_low_d;

   // -------------------------------------------------------------------------
   // Line sampling and baud counter
   // -------------------------------------------------------------------------
   line_sync u_sync_sda (.clk(I_CLK_SYS), .rst_n(I_RST_N), .ce(I_CE), .line_in(I_SDA),
      .line_out(sda_s));
   line_sync u_sync_scl (.clk(I_CLK_SYS), .rst_n(I_RST_N), .ce(I_CE), .line_in(I_SCL),
      .line_out(scl_s));
   baud_gen u_baud (.clk(I_CLK_SYS), .rst_n(I_RST_N), .ce(I_CE), .load(brg_load),
      .stop(brg_stop), .reload(baud_q), .timeout(brg_timeout));

   // -------------------------------------------------------------------------
   // AXI4-Lite write channel handling
   // -------------------------------------------------------------------------
   assign aw_take = I_S_AXI_AWVALID & awready_q;
   assign w_take = I_S_AXI_WVALID & wready_q;
   assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
   assign aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
   assign w_hold_d = (w_hold_q | w_take) & ~wr_fire;
   // Only byte lane 0 carries register data; other lanes are ignored
   assign wr_ctrl2 = wr_fire & w_en_q & (aw_addr_q == `OFS_CTRL2);
   assign wr_baud = wr_fire & w_en_q & (aw_addr_q == `OFS_BAUD);
   assign wr_xfer = wr_fire & w_en_q & (aw_addr_q == `OFS_XFER);
   assign wr_istat = wr_fire & w_en_q & (aw_addr_q == `OFS_IRQ_STAT);
   assign wr_imask = wr_fire & w_en_q & (aw_addr_q == `OFS_IRQ_MASK);
   assign wr_hit = (aw_addr_q == `OFS_CTRL2) | (aw_addr_q == `OFS_BAUD) |
                   (aw_addr_q == `OFS_STATUS) | (aw_addr_q == `OFS_XFER) |
                   (aw_addr_q == `OFS_IRQ_STAT) | (aw_addr_q == `OFS_IRQ_MASK);
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_en_q <= 1'b0;
      end else if (I_CE) begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awready_q <= ~aw_hold_d;
         wready_q <= ~w_hold_d;
         if (aw_take) begin
            aw_addr_q <= {I_S_AXI_AWADDR[`ADDR_W-1:2], 2'b00};
         end
         if (w_take) begin
            w_data_q <= I_S_AXI_WDATA[`REG_W-1:0];
            w_en_q <= I_S_AXI_WSTRB[0];
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (I_CE) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (I_S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------------
   assign rd_take = I_S_AXI_ARVALID & arready_q;
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case ({I_S_AXI_ARADDR[`ADDR_W-1:2], 2'b00})
         `OFS_CTRL2: rd_word[`REG_W-1:0] = ctrl2_q;
         `OFS_BAUD: rd_word[`BAUD_W-1:0] = baud_q;
         `OFS_STATUS: begin
            rd_word[`STATUS_START_BIT] = start_seen_q;
            rd_word[`STATUS_BUSY_BIT] = busy;
         end
         `OFS_XFER: rd_word[`REG_W-1:0] = xfer_q;
         `OFS_IRQ_STAT: rd_word[`IRQ_W-1:0] = irq_stat_q;
         `OFS_IRQ_MASK: rd_word[`IRQ_W-1:0] = irq_mask_q;
         default: rd_hit = 1'b0;
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
      end else if (I_CE) begin
         if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q & I_S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Start sequencer
   // -------------------------------------------------------------------------
   assign busy = (state_q == ST_SETUP) | (state_q == ST_HOLD);
   always_comb begin
      brg_load = 1'b0;
      brg_stop = 1'b0;
      coll = 1'b0;
      done = 1'b0;
      sda_low_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (ctrl2_q[`CTRL2_START_BIT]) begin
               if (sda_s & scl_s) begin
                  brg_load = 1'b1;
               end else begin
                  coll = 1'b1;
               end
            end
         end
         ST_SETUP: begin
            if (~scl_s | (brg_timeout & ~sda_s)) begin
               coll = 1'b1;
               brg_stop = 1'b1;
            end else if (brg_timeout) begin
               sda_low_d = 1'b1;
               brg_load = 1'b1;
            end
         end
         ST_HOLD: begin
            if (brg_timeout) begin
               done = 1'b1;
               brg_stop = 1'b1;
            end
         end
         ST_DONE: begin
         end
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         state_q <= ST_IDLE;
         O_SDA_OE <= 1'b0;
         start_seen_q <= 1'b0;
         // Fixed drive levels: SDA is only ever pulled low, SCL never
         O_SDA <= 1'b0;
         O_SCL <= 1'b0;
         O_SCL_OE <= 1'b0;
      end else if (I_CE) begin
         unique case (state_q)
            ST_IDLE: begin
               if (brg_load) begin
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (coll) begin
                  state_q <= ST_IDLE;
               end else if (sda_low_d) begin
                  state_q <= ST_HOLD;
                  O_SDA_OE <= 1'b1;
                  start_seen_q <= 1'b1;
               end
            end
            ST_HOLD: begin
               if (done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               // A control write with byte lane 0 enabled hands the line back; later phases own it then
               if (wr_ctrl2) begin
                  state_q <= ST_IDLE;
                  O_SDA_OE <= 1'b0;
                  start_seen_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         ctrl2_q <= `CTRL2_RST;
      end else if (I_CE) begin
         if (wr_ctrl2 & busy) begin
            // low bits locked; hardware clear of the request still lands
            ctrl2_q[`REG_W-1:`CTRL2_LOCK_MSB+1] <= w_data_q[`REG_W-1:`CTRL2_LOCK_MSB+1];
            ctrl2_q[`CTRL2_START_BIT] <= ctrl2_q[`CTRL2_START_BIT] & ~(coll | done);
         end else if (wr_ctrl2 & (state_q == ST_DONE)) begin
            // Release cycle never relaunches: the synchronisers still see SDA low
            ctrl2_q <= w_data_q & ~(`REG_W'(1) << `CTRL2_START_BIT);
         end else if (wr_ctrl2) begin
            ctrl2_q <= w_data_q;
         end else if (coll | done) begin
            ctrl2_q[`CTRL2_START_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         baud_q <= `BAUD_RST;
         xfer_q <= `XFER_RST;
         irq_mask_q <= `IRQ_RST;
      end else if (I_CE) begin
         if (wr_baud) begin
            baud_q <= w_data_q[`BAUD_W-1:0];
         end
         if (wr_xfer & ~busy) begin
            xfer_q <= w_data_q;
         end
         if (wr_imask) begin
            irq_mask_q <= w_data_q[`IRQ_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Interrupt status, write one to clear; a new event beats the clear
   // -------------------------------------------------------------------------
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_COLL_BIT] = coll;
      irq_set[`IRQ_WCLASH_BIT] = wr_xfer & busy;
      irq_set[`IRQ_DONE_BIT] = done;
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         irq_stat_q <= `IRQ_RST;
         O_IRQ <= 1'b0;
      end else if (I_CE) begin
         if (wr_istat) begin
            irq_stat_q <= (irq_stat_q & ~w_data_q[`IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         O_IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign O_S_AXI_AWREADY = awready_q;
   assign O_S_AXI_WREADY = wready_q;
   assign O_S_AXI_BVALID = bvalid_q;
   assign O_S_AXI_BRESP = bresp_q;
   assign O_S_AXI_ARREADY = arready_q;
   assign O_S_AXI_RVALID = rvalid_q;
   assign O_S_AXI_RDATA = rdata_q;
   assign O_S_AXI_RRESP = rresp_q;
endmodule

/* design/line_sync.sv */
// Two-flop synchroniser for one bus line, idles high like a pulled-up wire
module line_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Line in and synchronised level out
   input wire logic line_in,
   output logic line_out
);
   logic meta_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         line_out <= 1'b1;
      end else if (ce) begin
         meta_q <= line_in;
         line_out <= meta_q;
      end
   end
endmodule

/* pkg/i2c_start_params.svh */
// Register offsets, field positions, reset values and widths of the start generator
`ifndef I2C_START_PARAMS_SVH
`define I2C_START_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL2 8'h00
`define OFS_BAUD 8'h04
`define OFS_STATUS 8'h08
`define OFS_XFER 8'h0c
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14

// ----------------------------------------------------------------------------
// Fields and widths
// ----------------------------------------------------------------------------
`define ADDR_W 8
`define REG_W 8
`define BAUD_W 7
`define CTRL2_START_BIT 0
`define CTRL2_LOCK_MSB 4
`define STATUS_START_BIT 3
`define STATUS_BUSY_BIT 0
`define IRQ_W 3
`define IRQ_COLL_BIT 0
`define IRQ_WCLASH_BIT 1
`define IRQ_DONE_BIT 2

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define CTRL2_RST 8'h00
`define BAUD_RST 7'h7f
`define XFER_RST 8'h00
`define IRQ_RST 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* pkg/i2c_start_pkg.sv */
// Types shared by the start generator files
package i2c_start_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_HOLD,
      ST_DONE
   } start_state_t;
endpackage

/* testbench/i2c_bus_peer.sv */
// Other party on the bus: wired-and lines with pull-ups
module i2c_bus_peer (
   // Commands from the bench
   input wire logic i_pull_sda,
   input wire logic i_pull_scl,
   // Device drive and resolved lines
   input wire logic i_sda_oe,
   input wire logic i_scl_oe,
   output logic o_sda,
   output logic o_scl
);
   timeunit 1ns;
   timeprecision 100ps;
   always_comb begin
      o_sda = !(i_sda_oe || i_pull_sda);
      o_scl = !(i_scl_oe || i_pull_scl);
   end
endmodule

/* testbench/i2c_start_gen_sva.sv */
// Port checker for the start generator
module i2c_start_gen_sva (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_S_AXI_AWVALID,
   input wire logic O_S_AXI_AWREADY,
   input wire logic I_S_AXI_WVALID,
   input wire logic O_S_AXI_WREADY,
   input wire logic O_S_AXI_BVALID,
   input wire logic I_S_AXI_BREADY,
   input wire logic [1:0] O_S_AXI_BRESP,
   input wire logic I_S_AXI_ARVALID,
   input wire logic O_S_AXI_ARREADY,
   input wire logic O_S_AXI_RVALID,
   input wire logic I_S_AXI_RREADY,
   input wire logic [31:0] O_S_AXI_RDATA,
   input wire logic I_SDA,
   input wire logic I_SCL,
   input wire logic O_SDA,
   input wire logic O_SDA_OE,
   input wire logic O_SCL_OE
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_wr_taken;
      I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
   endsequence
   sequence s_wr_answer;
      !O_S_AXI_AWREADY ##1 O_S_AXI_BVALID;
   endsequence
   a_scl_never_driven: assert property (!O_SCL_OE)
      else $error("SCL driven");
   a_sda_only_low: assert property (O_SDA_OE |-> !O_SDA)
      else $error("SDA driven high");
   // Sync latency means the decision saw the lines a few edges back
   a_start_lines_idle: assert property (
      $rose(O_SDA_OE) |-> $past(I_SDA, 3) && $past(I_SCL, 3))
      else $error("SDA pulled without idle bus");
   a_release_on_write: assert property (
      $fell(O_SDA_OE) |-> $rose(O_S_AXI_BVALID))
      else $error("SDA released without write");
   a_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
      else $error("Write answer late");
   a_rd_answer: assert property (
      I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID && !O_S_AXI_ARREADY)
      else $error("Read answer late");
   a_b_holds: assert property (
      O_S_AXI_BVALID && !I_S_AXI_BREADY |=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP))
      else $error("Write response dropped");
   a_r_holds: assert property (
      O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA))
      else $error("Read data dropped");
endmodule

bind i2c_start_gen i2c_start_gen_sva i_sva (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
   .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
   .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
   .O_S_AXI_BVALID(O_S_AXI_BVALID), .I_S_AXI_BREADY(I_S_AXI_BREADY),
   .O_S_AXI_BRESP(O_S_AXI_BRESP), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
   .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RVALID(O_S_AXI_RVALID),
   .I_S_AXI_RREADY(I_S_AXI_RREADY), .O_S_AXI_RDATA(O_S_AXI_RDATA), .I_SDA(I_SDA),
   .I_SCL(I_SCL), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_SCL_OE(O_SCL_OE));

/* testbench/i2c_start_gen_tb.sv */
// Self-checking bench for the start generator
`include "i2c_start_params.svh"
module i2c_start_gen_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] BAUD = 7'h1f;
   localparam int N = 32;
   logic clk, rst_n, awv, wv, bry, arv, rry, pull_sda, pull_scl, oe_d, irq_d;
   logic [7:0] awa, ara;
   logic [31:0] wd;
   wire logic awry, wry, bv, arry, rv, sda, scl, sda_oe, scl_oe, irq;
   wire logic [1:0] brsp, rrsp;
   wire logic [31:0] rdat;
   int errors, total_checks, cyc, t_oe, t_irq, t_go;

   i2c_start_gen i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(1'b1),
      .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awry), .I_S_AXI_AWADDR(awa),
      .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wry), .I_S_AXI_WDATA(wd),
      .I_S_AXI_WSTRB(4'hf), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(bry),
      .O_S_AXI_BRESP(brsp), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arry),
      .I_S_AXI_ARADDR(ara), .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(rry),
      .O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rrsp), .I_SDA(sda), .O_SDA(),
      .O_SDA_OE(sda_oe), .I_SCL(scl), .O_SCL(), .O_SCL_OE(scl_oe), .O_IRQ(irq));
   i2c_bus_peer i_peer (.i_pull_sda(pull_sda), .i_pull_scl(pull_scl), .i_sda_oe(sda_oe),
      .i_scl_oe(scl_oe), .o_sda(sda), .o_scl(scl));

   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // Edge stamps of the drive and the interrupt
   always @(posedge clk) begin
      cyc <= cyc + 1;
      oe_d <= sda_oe;
      irq_d <= irq;
      if (sda_oe && !oe_d) t_oe <= cyc;
      if (irq && !irq_d) t_irq <= cyc;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Late BREADY on purpose so the response must stand
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge clk);
      awv <= 1; awa <= a; wv <= 1; wd <= d;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awv && awry) begin aw = 1; awv <= 0; end
         if (wv && wry) begin w = 1; wv <= 0; end
      end
      repeat (3) @(posedge clk);
      bry <= 1;
      do @(posedge clk); while (!bv);
      bry <= 0;
      chk({30'h0, brsp}, {30'h0, er});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      arv <= 1; ara <= a;
      do @(posedge clk); while (!arry);
      arv <= 0;
      @(posedge clk);
      rry <= 1;
      do @(posedge clk); while (!rv);
      rry <= 0;
      chk(rdat, e);
      chk({30'h0, rrsp}, {30'h0, er});
   endtask

   task automatic t_reset_regs;
      rchk(`OFS_CTRL2, 32'h0, `RESP_OKAY);
      rchk(`OFS_BAUD, 32'h7f, `RESP_OKAY);
      rchk(`OFS_STATUS, 32'h0, `RESP_OKAY);
      rchk(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
      rchk(8'h18, 32'h0, `RESP_SLVERR);
      wchk(8'h18, 32'hff, `RESP_SLVERR);
   endtask
   task automatic t_start;
      int n;
      wchk(`OFS_BAUD, {25'h0, BAUD}, `RESP_OKAY);
      wchk(`OFS_IRQ_MASK, 32'h4, `RESP_OKAY);
      wchk(`OFS_CTRL2, 32'h1, `RESP_OKAY);
      t_go = cyc;
      rchk(`OFS_STATUS, 32'h1, `RESP_OKAY);
      wchk(`OFS_XFER, 32'ha5, `RESP_OKAY);
      rchk(`OFS_XFER, 32'h0, `RESP_OKAY);
      // Upper bits still land while the low five are locked
      wchk(`OFS_CTRL2, 32'he0, `RESP_OKAY);
      rchk(`OFS_CTRL2, 32'he1, `RESP_OKAY);
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      // Edge stamps land by non-blocking update; let them settle first
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, (t_oe - t_go >= N - 1) && (t_oe - t_go <= N + 5)}, 32'h1);
      chk({31'h0, (t_irq - t_oe >= N) && (t_irq - t_oe <= N + 4)}, 32'h1);
      chk({31'h0, sda}, 32'h0);
      chk({31'h0, scl}, 32'h1);
      rchk(`OFS_STATUS, 32'h8, `RESP_OKAY);
      rchk(`OFS_CTRL2, 32'he0, `RESP_OKAY);
      rchk(`OFS_IRQ_STAT, 32'h6, `RESP_OKAY);
      wchk(`OFS_XFER, 32'h5a, `RESP_OKAY);
      rchk(`OFS_XFER, 32'h5a, `RESP_OKAY);
      wchk(`OFS_IRQ_STAT, 32'h6, `RESP_OKAY);
      rchk(`OFS_IRQ_STAT, 32'h0, `RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wchk(`OFS_CTRL2, 32'h0, `RESP_OKAY);
      chk({31'h0, sda}, 32'h1);
   endtask
   // Pass 0: bus held low at start; pass 1: SCL lost mid-interval; pass 2: SDA low at timeout
   task automatic t_collision;
      int t;
      wchk(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         t = t_oe;
         if (k == 0) begin
            pull_sda <= 1;
            pull_scl <= 1;
         end
         repeat (4) @(posedge clk);
         wchk(`OFS_CTRL2, 32'h1, `RESP_OKAY);
         if (k > 0) begin
            repeat (8) @(posedge clk);
            if (k == 1) pull_scl <= 1;
            else pull_sda <= 1;
         end
         repeat (2 * N) @(posedge clk);
         chk(t_oe, t);
         chk({31'h0, irq}, 32'h1);
         rchk(`OFS_CTRL2, 32'h0, `RESP_OKAY);
         rchk(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
         pull_sda <= 0;
         pull_scl <= 0;
         wchk(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
         chk({31'h0, irq}, 32'h0);
      end
   endtask

   task automatic end_of_test;
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      rst_n = 0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
      awa = 8'h00; ara = 8'h00; wd = 32'h0; pull_sda = 0; pull_scl = 0;
      oe_d = 0; irq_d = 0; cyc = 0; t_oe = 0; t_irq = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1;
      t_reset_regs;
      t_start;
      t_collision;
      end_of_test;
   end
   // Whole run is well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test;
   end
endmodule
